// ==== hw/ccpd_top.sv ====
// Output clock gating with stop inputs and power-down sequencing
//
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Host stop takes or releases effect within one free-running bus clock rise.
// - Bus stop enables or disables outputs within one free-running bus clock rise.
// - First valid clocks follow power-down release in under 3 ms.
// - Host stop passes a synchroniser before gating any output.
// - Host stop gates host and fixed 66 outputs only.
// - Host outputs halt low and restart with a full high pulse.
// - Stoppable bus outputs halt low, restart full, others undisturbed.
// - Power-down pin is synchronised before the power-down sequence starts.
// - All outputs are parked low before oscillator and crystal turn off.
// - Internal clocks stop once power-down is entered.
// - Host outputs stop low at the next host clock fall.
// - Both stop inputs are ignored during power-down entry, hold and exit.
// - Reference and usb rate outputs park low soon, reference maybe slower.
// - Power-down entry is as short as the ordering allows.
// - Interrupt, reference and usb rate clocks ignore host stop.
// - Free-running bus clock ignores bus stop, runs unless powered down.
module ccpd_top
    import ccpd_pkg::*;
#(
    parameter int WAKE_CYC = CCPD_WAKE_CYC
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic [31:0]       hrdata,
    output logic              hresp,
    input  wire logic         host_stop_n,
    input  wire logic         bus_stop_n,
    input  wire logic         powerdown_input_n,
    output logic              host_clock_out,
    output logic              fixed_66_clock_out,
    output logic              bus_clock_freerun,
    output logic              bus_clock_out,
    output logic              intc_clock_out,
    output logic              ref_clock_out,
    output logic              usb_rate_clock_out,
    output logic              osc_enable,
    output logic              xtal_enable
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [2:0]               pins_sync;
    logic                     host_stop_s;
    logic                     bus_stop_s;
    logic                     powerdown_n;

    ccpd_sync #(
        .WIDTH   (3),
        .RST_VAL (1'b1)
    ) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       ({powerdown_input_n, bus_stop_n, host_stop_n}),
        .q       (pins_sync)
    );

    // Only synchronised copies are read below
    assign host_stop_s = ~pins_sync[0];
    assign bus_stop_s  = ~pins_sync[1];
    assign powerdown_n = pins_sync[2];

    // ****************************************************************
    // AHB-Lite slave
    // ****************************************************************
    logic [1:0]               ctrl_r;
    logic                     wr_pend_r;
    logic                     rd_pend_r;
    logic [7:0]               addr_r;
    logic                     acc;
    logic [31:0]              stat_word;
    logic [CCPD_NOUT-1:0]     gate_r;
    ccpd_state_e              state_r;
    logic                     host_stop_q_r;
    logic                     bus_stop_q_r;

    assign acc       = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= 8'h00;
        end else begin
            wr_pend_r <= acc & hwrite;
            rd_pend_r <= acc & ~hwrite;
            if (acc) begin
                addr_r <= haddr[7:0];
            end
        end
    end

    // Software may mask each stop pin; reset honours both
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= CCPD_CTRL_RST;
        end else if (wr_pend_r && addr_r == CCPD_CTRL_OFS) begin
            ctrl_r <= hwdata[1:0];
        end
    end

    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[CCPD_STAT_GATE_B +: CCPD_NOUT] = gate_r;
        stat_word[CCPD_STAT_ST_B +: 2] = state_r;
        stat_word[CCPD_STAT_OSC_B]  = osc_enable;
        stat_word[CCPD_STAT_HSTP_B] = host_stop_q_r;
        stat_word[CCPD_STAT_BSTP_B] = bus_stop_q_r;
    end

    // Unmapped reads return zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (acc && !hwrite) begin
            case (haddr[7:0])
                CCPD_CTRL_OFS: hrdata <= {30'h0000_0000, ctrl_r};
                CCPD_STAT_OFS: hrdata <= stat_word;
                default:       hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // Internal clock divider
    // ****************************************************************
    logic [CCPD_DIV_W-1:0]    div_r;
    logic [CCPD_DIV_W-1:0]    div_nxt;
    logic                     div_run;
    logic [CCPD_NOUT-1:0]     src_nxt;
    logic                     free_rise;

    // Divider halts while oscillators are off
    assign div_run = (state_r != CCPD_OFF);
    assign div_nxt = div_run ? div_r + 5'h01 : div_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_r <= 5'h00;
        end else begin
            div_r <= div_nxt;
        end
    end

    assign src_nxt[CCPD_I_HOST] = div_nxt[0];
    assign src_nxt[CCPD_I_F66]  = div_nxt[1];
    assign src_nxt[CCPD_I_FREE] = div_nxt[2];
    assign src_nxt[CCPD_I_BUS]  = div_nxt[2];
    assign src_nxt[CCPD_I_INTC] = div_nxt[4];
    assign src_nxt[CCPD_I_REF]  = div_nxt[3];
    assign src_nxt[CCPD_I_USB]  = div_nxt[1];
    assign free_rise = div_nxt[2] & ~div_r[2];

    // ****************************************************************
    // Stop requests, taken on free-running bus clock rises
    // ****************************************************************
    // Agent is expected to move the pins one hclk edge after that rise
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            host_stop_q_r <= 1'b0;
            bus_stop_q_r  <= 1'b0;
        end else if (state_r != CCPD_RUN) begin
            host_stop_q_r <= 1'b0;
            bus_stop_q_r  <= 1'b0;
        end else if (free_rise) begin
            host_stop_q_r <= host_stop_s & ctrl_r[CCPD_CTRL_HOST_B];
            bus_stop_q_r  <= bus_stop_s & ctrl_r[CCPD_CTRL_BUS_B];
        end
    end

    // ****************************************************************
    // Output gates
    // ****************************************************************
    logic [CCPD_NOUT-1:0]     want;
    logic [CCPD_NOUT-1:0]     gate_nxt;
    logic [CCPD_NOUT-1:0]     out_r;
    logic                     run;

    assign run = (state_r == CCPD_RUN);

    always_comb begin
        want = {CCPD_NOUT{run}};
        want[CCPD_I_HOST] = run & ~host_stop_q_r;
        want[CCPD_I_F66]  = run & ~host_stop_q_r;
        want[CCPD_I_BUS]  = run & ~bus_stop_q_r;
    end

    // Switching only in the low phase keeps every pulse full width
    assign gate_nxt = (src_nxt & gate_r) | (~src_nxt & want);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gate_r <= {CCPD_NOUT{1'b0}};
            out_r  <= {CCPD_NOUT{1'b0}};
        end else begin
            gate_r <= gate_nxt;
            out_r  <= src_nxt & gate_nxt;
        end
    end

    assign host_clock_out     = out_r[CCPD_I_HOST];
    assign fixed_66_clock_out = out_r[CCPD_I_F66];
    assign bus_clock_freerun  = out_r[CCPD_I_FREE];
    assign bus_clock_out      = out_r[CCPD_I_BUS];
    assign intc_clock_out     = out_r[CCPD_I_INTC];
    assign ref_clock_out      = out_r[CCPD_I_REF];
    assign usb_rate_clock_out = out_r[CCPD_I_USB];

    // ****************************************************************
    // Power-down sequencer
    // ****************************************************************
    logic [CCPD_WAKE_W-1:0]   wake_cnt_r;
    logic                     parked;

    // Reference may need up to half its period to reach its low phase
    assign parked = (gate_r == {CCPD_NOUT{1'b0}}) && (out_r == {CCPD_NOUT{1'b0}});

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= CCPD_RUN;
        end else begin
            case (state_r)
                CCPD_RUN: begin
                    if (!powerdown_n) begin
                        state_r <= CCPD_PARK;
                    end
                end
                CCPD_PARK: begin
                    // Leave as soon as all outputs sit low
                    if (parked) begin
                        state_r <= CCPD_OFF;
                    end
                end
                CCPD_OFF: begin
                    if (powerdown_n) begin
                        state_r <= CCPD_WAKE;
                    end
                end
                CCPD_WAKE: begin
                    if (wake_cnt_r >= WAKE_CYC[CCPD_WAKE_W-1:0] - 18'h00002) begin
                        state_r <= CCPD_RUN;
                    end
                end
                default: state_r <= CCPD_RUN;
            endcase
        end
    end

    // Settling time for oscillator restart
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_cnt_r <= '0;
        end else if (state_r == CCPD_WAKE) begin
            wake_cnt_r <= wake_cnt_r + 18'h00001;
        end else begin
            wake_cnt_r <= '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            osc_enable  <= 1'b1;
            xtal_enable <= 1'b1;
        end else begin
            osc_enable  <= (state_r != CCPD_OFF) || powerdown_n;
            xtal_enable <= (state_r != CCPD_OFF) || powerdown_n;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_pd_seen;
        (state_r == CCPD_RUN) && !powerdown_n;
    endsequence

    sequence s_parking;
        state_r == CCPD_PARK;
    endsequence

    a_host_stop_latency: assert property (@(posedge hclk) disable iff (!hresetn)
        host_stop_q_r && run |-> ##[0:2] !gate_r[CCPD_I_HOST])
        else $error("host gate not closed after stop");

    a_bus_halts_low: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(gate_r[CCPD_I_BUS]) |-> !bus_clock_out && !$past(src_nxt[CCPD_I_BUS]))
        else $error("bus gate closed mid pulse");

    a_host_full_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(host_clock_out) |=> !host_clock_out ##1 (host_clock_out || !gate_r[CCPD_I_HOST]))
        else $error("host pulse truncated");

    a_park_before_off: assert property (@(posedge hclk) disable iff (!hresetn)
        !osc_enable |-> out_r == {CCPD_NOUT{1'b0}} && gate_r == {CCPD_NOUT{1'b0}})
        else $error("oscillator off with output active");

    a_stop_ignored_pd: assert property (@(posedge hclk) disable iff (!hresetn)
        !run |=> !host_stop_q_r && !bus_stop_q_r)
        else $error("stop honoured during power-down");

    a_freerun_toggles: assert property (@(posedge hclk) disable iff (!hresetn)
        (run && gate_r[CCPD_I_FREE])[*5] |-> bus_clock_freerun != $past(bus_clock_freerun, 4))
        else $error("free-running bus clock stuck");

    a_pd_stop_fast: assert property (@(posedge hclk) disable iff (!hresetn)
        s_pd_seen ##1 s_parking |-> ##2 (!host_clock_out && !gate_r[CCPD_I_HOST]))
        else $error("host output not stopped at next fall");

    a_wake_bound: assert property (@(posedge hclk) disable iff (!hresetn)
        state_r == CCPD_WAKE |-> wake_cnt_r < WAKE_CYC[CCPD_WAKE_W-1:0])
        else $error("power-up latency exceeded");

    a_div_frozen_off: assert property (@(posedge hclk) disable iff (!hresetn)
        state_r == CCPD_OFF && $past(state_r) == CCPD_OFF |-> $stable(div_r))
        else $error("internal clocks run in power-down");

    a_park_bounded: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(state_r == CCPD_PARK) |-> ##[1:18] state_r == CCPD_OFF)
        else $error("parking took too long");

    a_intc_ignores_stop: assert property (@(posedge hclk) disable iff (!hresetn)
        host_stop_q_r && run |-> gate_r[CCPD_I_INTC] || !$past(run))
        else $error("interrupt clock gated by host stop");

    a_bus_stop_latency: assert property (@(posedge hclk) disable iff (!hresetn)
        bus_stop_q_r && run |-> ##[0:4] !gate_r[CCPD_I_BUS])
        else $error("bus gate not closed after stop");

endmodule : ccpd_top
`default_nettype wire

// ==== hw/ccpd_pkg.sv ====
// Constants and types for the output clock stop and power-down block
`default_nettype none
package ccpd_pkg;

    // ****************************************************************
    // Register map (AHB-Lite, one word each)
    // ****************************************************************
    localparam logic [7:0]  CCPD_CTRL_OFS    = 8'h00;
    localparam logic [7:0]  CCPD_STAT_OFS    = 8'h04;
    localparam int          CCPD_CTRL_HOST_B = 0;
    localparam int          CCPD_CTRL_BUS_B  = 1;
    localparam logic [1:0]  CCPD_CTRL_RST    = 2'h3;
    localparam int          CCPD_STAT_GATE_B = 0;
    localparam int          CCPD_STAT_ST_B   = 8;
    localparam int          CCPD_STAT_OSC_B  = 10;
    localparam int          CCPD_STAT_HSTP_B = 11;
    localparam int          CCPD_STAT_BSTP_B = 12;

    // ****************************************************************
    // Output clock indices
    // ****************************************************************
    localparam int          CCPD_NOUT   = 7;
    localparam int          CCPD_I_HOST = 0;
    localparam int          CCPD_I_F66  = 1;
    localparam int          CCPD_I_FREE = 2;
    localparam int          CCPD_I_BUS  = 3;
    localparam int          CCPD_I_INTC = 4;
    localparam int          CCPD_I_REF  = 5;
    localparam int          CCPD_I_USB  = 6;
    localparam int          CCPD_DIV_W  = 5;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int          CCPD_CLK_NS     = 20;
    localparam int          CCPD_PWRUP_MS   = 3;
    localparam int          CCPD_WAKE_CYC   = CCPD_PWRUP_MS * 1000000 / CCPD_CLK_NS - 1;
    localparam int          CCPD_WAKE_W     = 18;

    // ****************************************************************
    // Power state
    // ****************************************************************
    typedef enum logic [1:0] {
        CCPD_RUN  = 2'b00,
        CCPD_PARK = 2'b01,
        CCPD_OFF  = 2'b10,
        CCPD_WAKE = 2'b11
    } ccpd_state_e;

endpackage : ccpd_pkg
`default_nettype wire

// ==== hw/ccpd_sync.sv ====
// Two-flop level synchroniser, one per asynchronous pin
`timescale 1ns/1ps
`default_nettype none
module ccpd_sync #(
    parameter int        WIDTH = 1,
    parameter logic      RST_VAL = 1'b1
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic [WIDTH-1:0]  d,
    output logic      [WIDTH-1:0]  q
);

    logic [WIDTH-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r <= {WIDTH{RST_VAL}};
            q      <= {WIDTH{RST_VAL}};
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule : ccpd_sync
`default_nettype wire

// ==== bench/ccpd_agent.sv ====
// Model of the external clock control agent driving the stop and power-down pins
`timescale 1ns/1ps
`default_nettype none
module ccpd_agent (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic bus_clock_freerun,
    input  wire logic want_host_n,
    input  wire logic want_bus_n,
    input  wire logic want_pd_n,
    output logic      host_stop_n,
    output logic      bus_stop_n,
    output logic      powerdown_input_n
);
    // ****************************************************************
    // Pin drivers
    // ****************************************************************
    logic fr_q_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fr_q_r <= 1'b0;
        end else begin
            fr_q_r <= bus_clock_freerun;
        end
    end

    // Stop pins move only just after a free-running rise, never mid-cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            host_stop_n <= 1'b1;
            bus_stop_n  <= 1'b1;
        end else if (bus_clock_freerun && !fr_q_r) begin
            host_stop_n <= want_host_n;
            bus_stop_n  <= want_bus_n;
        end
    end

    // Power-down is asynchronous, so it passes straight through
    assign powerdown_input_n = want_pd_n;
endmodule : ccpd_agent
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking testbench for the clock stop and power-down block
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ccpd_pkg::*;
;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    localparam int WAKE = 20;
    localparam logic [CCPD_NOUT-1:0] HOST_GRP = 7'h03;
    localparam logic [CCPD_NOUT-1:0] BUS_GRP  = 7'h08;
    localparam int WID [3] = '{1, 2, 4};
    logic         hclk, hresetn, hsel, hwrite, want_host_n, want_bus_n, want_pd_n, osc_q;
    logic [31:0]  haddr, hwdata;
    logic [1:0]   htrans;
    logic [2:0]   hsize;
    wire logic    hreadyout, hresp, host_stop_n, bus_stop_n, pd_n, osc_enable, xtal_enable;
    wire logic [31:0] hrdata;
    wire logic [CCPD_NOUT-1:0] outs;
    int           num_errors = 0;
    int           n_checks = 0;
    int           rises [CCPD_NOUT];
    int           hi_len [3] = '{0, 0, 0};
    int           first_fr, last_fr;

    ccpd_top #(.WAKE_CYC(WAKE)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .host_stop_n(host_stop_n), .bus_stop_n(bus_stop_n), .powerdown_input_n(pd_n),
        .host_clock_out(outs[CCPD_I_HOST]), .fixed_66_clock_out(outs[CCPD_I_F66]),
        .bus_clock_freerun(outs[CCPD_I_FREE]), .bus_clock_out(outs[CCPD_I_BUS]),
        .intc_clock_out(outs[CCPD_I_INTC]), .ref_clock_out(outs[CCPD_I_REF]),
        .usb_rate_clock_out(outs[CCPD_I_USB]), .osc_enable(osc_enable),
        .xtal_enable(xtal_enable));

    ccpd_agent agent (
        .hclk(hclk), .hresetn(hresetn), .bus_clock_freerun(outs[CCPD_I_FREE]),
        .want_host_n(want_host_n), .want_bus_n(want_bus_n), .want_pd_n(want_pd_n),
        .host_stop_n(host_stop_n), .bus_stop_n(bus_stop_n), .powerdown_input_n(pd_n));

    // ****************************************************************
    // Reporting and compare tasks
    // ****************************************************************
    task automatic close_out();
        $display("Checks made: %0d, mismatches: %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    task automatic fail(input string msg);
        $display("[FAIL] %0t %s", $time, msg);
        num_errors++;
    endtask : fail

    task automatic give_up(input string msg);
        fail(msg);
        close_out();
    endtask : give_up

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_checks++;
        if (got !== exp) fail(msg);
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        n_checks++;
        if (got !== exp) fail(msg);
    endtask : chk_bit

    // ****************************************************************
    // Bus, pin and output helpers
    // ****************************************************************
    task automatic bus_edge();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) give_up("bus wait timed out");
    endtask : bus_edge

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= 3'h2;
        bus_edge();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        bus_edge();
        rd = hrdata;
        chk_bit(hresp, 1'b0, "response not okay");
    endtask : ahb

    task automatic wait_pin(input logic on_bus, input logic val);
        int n;
        n = 0;
        while ((on_bus ? bus_stop_n : host_stop_n) !== val && n < 64) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 64) give_up("stop pin never moved");
    endtask : wait_pin

    // Counts output rises and the free-running rises seen before the target rises
    task automatic track(input int sel, input int cyc);
        logic [CCPD_NOUT-1:0] prev;
        int fr;
        fr = 0;
        first_fr = -1;
        last_fr = -1;
        foreach (rises[i]) rises[i] = 0;
        @(negedge hclk);
        prev = outs;
        repeat (cyc) begin
            @(negedge hclk);
            for (int i = 0; i < CCPD_NOUT; i++) if (outs[i] && !prev[i]) rises[i]++;
            if (outs[sel] && !prev[sel]) begin
                if (first_fr < 0) first_fr = fr;
                last_fr = fr;
            end
            if (outs[CCPD_I_FREE] && !prev[CCPD_I_FREE]) fr++;
            prev = outs;
        end
    endtask : track

    // High pulse widths and park order, watched all run long
    always @(negedge hclk) begin
        for (int k = 0; k < 3; k++) begin
            if (outs[k == 2 ? CCPD_I_BUS : k]) hi_len[k]++;
            else if (hi_len[k] != 0) begin
                chk_word(hi_len[k], WID[k], "truncated high pulse");
                hi_len[k] = 0;
            end
        end
        if (osc_q === 1'b1 && osc_enable === 1'b0)
            chk_word(32'(outs), 32'h0, "oscillator off before outputs parked");
        osc_q = osc_enable;
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic reg_case();
        logic [31:0] rd;
        ahb(1'b0, 32'(CCPD_CTRL_OFS), 32'h0, rd);
        chk_word(rd, 32'(CCPD_CTRL_RST), "control reset value");
        ahb(1'b1, 32'(CCPD_STAT_OFS), 32'hffffffff, rd);
        ahb(1'b0, 32'(CCPD_STAT_OFS), 32'h0, rd);
        chk_word(rd & 32'h00001f00, 32'h00000400, "status reset value");
        ahb(1'b0, 32'h00000008, 32'h0, rd);
        chk_word(rd, 32'h0, "unmapped read");
    endtask : reg_case

    task automatic stop_case(input logic on_bus, input int sel,
                             input logic [CCPD_NOUT-1:0] grp, input logic honour);
        logic [31:0] rd;
        @(posedge hclk);
        if (on_bus) want_bus_n <= 1'b0;
        else want_host_n <= 1'b0;
        wait_pin(on_bus, 1'b0);
        track(sel, 64);
        if (honour) chk_bit(last_fr <= 1, 1'b1, "stop too late");
        track(sel, 128);
        for (int i = 0; i < CCPD_NOUT; i++)
            chk_bit(rises[i] > 0, !(honour && grp[i]), "wrong set running");
        if (honour) chk_word(32'(outs & grp), 32'h0, "stopped output not low");
        ahb(1'b0, 32'(CCPD_STAT_OFS), 32'h0, rd);
        chk_bit(rd[on_bus ? CCPD_STAT_BSTP_B : CCPD_STAT_HSTP_B], honour, "stop flag");
        if (on_bus) want_bus_n <= 1'b1;
        else want_host_n <= 1'b1;
        wait_pin(on_bus, 1'b1);
        track(sel, 64);
        chk_bit(first_fr >= 0 && first_fr <= 1, 1'b1, "restart too late");
    endtask : stop_case

    task automatic mask_case();
        logic [31:0] rd;
        ahb(1'b1, 32'(CCPD_CTRL_OFS), 32'h0, rd);
        ahb(1'b0, 32'(CCPD_CTRL_OFS), 32'h0, rd);
        chk_word(rd, 32'h0, "control write");
        stop_case(1'b0, CCPD_I_HOST, HOST_GRP, 1'b0);
        ahb(1'b1, 32'(CCPD_CTRL_OFS), 32'(CCPD_CTRL_RST), rd);
    endtask : mask_case

    task automatic pd_case();
        logic [31:0] rd;
        int n;
        want_pd_n <= 1'b0;
        n = 0;
        while (osc_enable !== 1'b0 && n < 40) begin
            @(posedge hclk);
            n++;
        end
        chk_bit(osc_enable, 1'b0, "oscillator still on");
        chk_bit(xtal_enable, 1'b0, "crystal still on");
        track(CCPD_I_FREE, 100);
        for (int i = 0; i < CCPD_NOUT; i++)
            chk_word(rises[i], 32'h0, "clock runs in power-down");
        ahb(1'b0, 32'(CCPD_STAT_OFS), 32'h0, rd);
        chk_word(32'(rd[9:8]), 32'(CCPD_OFF), "state not off");
        want_pd_n <= 1'b0 | 1'b1;
        n = 0;
        while (outs[CCPD_I_HOST] !== 1'b1 && n < WAKE + 80) begin
            @(posedge hclk);
            n++;
        end
        chk_bit(outs[CCPD_I_HOST], 1'b1, "no clock after wake");
        chk_bit(osc_enable, 1'b1, "oscillator not back on");
    endtask : pd_case

    // ****************************************************************
    // Clock, reset and main sequence
    // ****************************************************************
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        want_host_n = 1'b1;
        want_bus_n = 1'b1;
        want_pd_n = 1'b1;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        reg_case();
        stop_case(1'b0, CCPD_I_HOST, HOST_GRP, 1'b1);
        stop_case(1'b1, CCPD_I_BUS, BUS_GRP, 1'b1);
        mask_case();
        pd_case();
        close_out();
    end
endmodule : testbench
`default_nettype wire
